// File: src/yc_sep.v
// Standard select, Y/C separation and chroma demodulation front end
// Assumes aclk is the internal halved 8x subcarrier clock and a same-domain sample stream
`timescale 1ns/100ps
`include "yc_sep_consts.vh"
module yc_sep #(
  parameter DW = 8
)(
  // Clock and reset
  input  wire          aclk,
  input  wire          aresetn,
  // AXI4-Lite slave
  input  wire [7:0]    s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [7:0]    s_axi_araddr,
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  // Digitized video in, from a same-clock front end
  input  wire [DW-1:0] comp_in,
  input  wire [DW-1:0] chroma_in,
  input  wire          sample_valid,
  // Separated, demodulated video out
  output reg  [DW-1:0] luma_out,
  output reg  [DW-1:0] cd1_out,
  output reg  [DW-1:0] cd2_out,
  output reg           iq_mode,
  output reg           out_valid
);
  // Standard select, kept at its last legal code
  reg [2:0]  std_reg;
  // Cropping window, stored for software only
  reg [7:0]  hstart_reg;
  reg [7:0]  vstart_reg;
  reg [7:0]  vheight_reg;
  reg [7:0]  winhi_reg;
  reg [7:0]  hwidth_reg;
  // Scaling ratio and gate offsets, stored for software only
  reg [15:0] hratio_reg;
  reg [7:0]  agc_reg;
  reg [7:0]  burst_reg;
  // Datapath control and saturation gains
  reg [7:0]  path_reg;
  reg [7:0]  u_gain_reg;
  reg [7:0]  v_gain_reg;
  // Write channel holding; address and data may arrive in either order
  reg        aw_full_reg;
  reg        w_full_reg;
  reg [7:0]  awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0]  wstrb_reg;
  // Writes land when both halves are held and no answer is pending
  wire       wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;
  // Each ready falls while its item is held
  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready  = !w_full_reg;
  assign s_axi_arready = !s_axi_rvalid;

  // Write data with byte-lane merge into 8- or 16-bit fields
  wire [7:0] wb0 = wstrb_reg[0] ? wdata_reg[7:0] : 8'h00;
  // Eight-bit registers take lane 0 only; upper lanes are ignored
  wire       lane0 = wstrb_reg[0];
  wire       lane1 = wstrb_reg[1];
  // Unmapped or unaligned address answers SLVERR and writes nothing
  wire       addr_ok = (awaddr_reg[1:0] == 2'h0) &&
                       (awaddr_reg >= `ADDR_STD_CTRL) && (awaddr_reg <= `ADDR_STATUS);
  wire [2:0] new_std = wb0[`STD_MSB:`STD_LSB];
  // Code 000 is reserved and leaves the standard untouched
  wire       std_valid = (new_std != 3'h0);

  // Write address/data capture, register update and response
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg  <= 1'b0;
      w_full_reg   <= 1'b0;
      awaddr_reg   <= 8'h00;
      wdata_reg    <= 32'h0000_0000;
      wstrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      std_reg      <= `RST_STD;
      hstart_reg   <= `RST_BYTE;
      vstart_reg   <= `RST_BYTE;
      vheight_reg  <= `RST_BYTE;
      winhi_reg    <= `RST_BYTE;
      hwidth_reg   <= `RST_BYTE;
      // Ratio and gate offsets reset to the first standard's values
      hratio_reg   <= `RST_HRATIO;
      agc_reg      <= `RST_AGC;
      burst_reg    <= `RST_BURST;
      path_reg     <= `RST_PATH;
      u_gain_reg   <= `RST_GAINS;
      v_gain_reg   <= `RST_GAINS;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full_reg)
      begin
        aw_full_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_reg)
      begin
        w_full_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go)
      begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_ok ? 2'h0 : 2'h2;
        if (lane0)
        begin
          case (awaddr_reg)
            `ADDR_STD_CTRL:   if (std_valid) std_reg <= new_std;
            `ADDR_HSTART:     hstart_reg  <= wdata_reg[7:0];
            `ADDR_VSTART:     vstart_reg  <= wdata_reg[7:0];
            `ADDR_VHEIGHT:    vheight_reg <= wdata_reg[7:0];
            `ADDR_WIN_HI:     winhi_reg   <= wdata_reg[7:0];
            `ADDR_HWIDTH:     hwidth_reg  <= wdata_reg[7:0];
            `ADDR_HRATIO:     hratio_reg[7:0] <= wdata_reg[7:0];
            `ADDR_AGC_GATE:   agc_reg     <= wdata_reg[7:0];
            `ADDR_BURST_GATE: burst_reg   <= wdata_reg[7:0];
            `ADDR_PATH_CTRL:  path_reg    <= wdata_reg[7:0];
            `ADDR_GAINS:      u_gain_reg  <= wdata_reg[7:0];
            default:          ;
          endcase
        end
        // Sixteen-bit fields take their high byte from lane 1
        if (lane1)
        begin
          case (awaddr_reg)
            `ADDR_HRATIO: hratio_reg[15:8] <= wdata_reg[15:8];
            `ADDR_GAINS:  v_gain_reg <= wdata_reg[15:8];
            default:      ;
          endcase
        end
      end
    end
  end

  // Standard family decode
  // PAL-M is a 525-line standard with PAL colour, so it is not I/Q
  wire is_ntsc  = (std_reg == `STD_NTSC_M) || (std_reg == `STD_NTSC_J);
  wire is_525   = is_ntsc || (std_reg == `STD_PAL_M);
  wire is_secam = (std_reg == `STD_SECAM);
  // Live datapath status
  wire [31:0] status_word = {24'h000000, 3'h0, out_valid, is_secam,
                             is_525, iq_mode, path_reg[`PC_SVIDEO]};

  // Read channel
  reg [31:0] rd_mux;
  reg        rd_ok;
  always @*
  begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      `ADDR_STD_CTRL:   rd_mux = {29'h0, std_reg};
      `ADDR_HSTART:     rd_mux = {24'h0, hstart_reg};
      `ADDR_VSTART:     rd_mux = {24'h0, vstart_reg};
      `ADDR_VHEIGHT:    rd_mux = {24'h0, vheight_reg};
      `ADDR_WIN_HI:     rd_mux = {24'h0, winhi_reg};
      `ADDR_HWIDTH:     rd_mux = {24'h0, hwidth_reg};
      `ADDR_HRATIO:     rd_mux = {16'h0, hratio_reg};
      `ADDR_AGC_GATE:   rd_mux = {24'h0, agc_reg};
      `ADDR_BURST_GATE: rd_mux = {24'h0, burst_reg};
      `ADDR_PATH_CTRL:  rd_mux = {24'h0, path_reg};
      `ADDR_GAINS:      rd_mux = {16'h0, v_gain_reg, u_gain_reg};
      `ADDR_STATUS:     rd_mux = status_word;
      default:          rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end
    // One read at a time: arready stays low while the answer stands
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Composite delay line, five taps; tap 2 is the centre sample
  // Odd taps carry no weight at fsc but keep the even taps two samples apart
  reg signed [DW-1:0] tap0;
  reg signed [DW-1:0] tap1;
  reg signed [DW-1:0] tap2;
  reg signed [DW-1:0] tap3;
  reg signed [DW-1:0] tap4;
  reg        [1:0]    phase_reg;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tap0 <= {DW{1'b0}};
      tap1 <= {DW{1'b0}};
      tap2 <= {DW{1'b0}};
      tap3 <= {DW{1'b0}};
      tap4 <= {DW{1'b0}};
      phase_reg <= 2'h0;
    end
    else if (sample_valid)
    begin
      tap0 <= path_reg[`PC_SVIDEO] ? chroma_in : comp_in;
      tap1 <= tap0;
      tap2 <= tap1;
      tap3 <= tap2;
      tap4 <= tap3;
      phase_reg <= phase_reg + 2'h1; // 4x subcarrier sample phase
    end
  end

  // Band-pass at fsc, kernel (1,0,-2,0,1)/4, which inverts the chroma sign
  // Notch adds it back to the centre tap, cancelling the fsc component
  wire signed [DW+2:0] bp_sum = {{3{tap0[DW-1]}}, tap0} + {{3{tap4[DW-1]}}, tap4}
                               - {{2{tap2[DW-1]}}, tap2, 1'b0};
  wire signed [DW-1:0] chroma_bp = bp_sum[DW+1:2];
  wire signed [DW-1:0] luma_notch = tap2 + chroma_bp;
  wire        sep_on = path_reg[`PC_SEP_EN] && !path_reg[`PC_SVIDEO];
  // S-Video chroma direct, composite chroma from band-pass
  wire signed [DW-1:0] chroma_sel = path_reg[`PC_SVIDEO] ? tap2 : (sep_on ? chroma_bp : {DW{1'b0}});
  wire signed [DW-1:0] luma_sel   = path_reg[`PC_SVIDEO] ? comp_in : (sep_on ? luma_notch : tap2);

  // Demodulate by quadrature phase, then saturation gain
  // At four samples per cycle each phase lands on one axis, so no sine table
  reg  signed [DW-1:0] d1;
  reg  signed [DW-1:0] d2;
  always @*
  begin
    d1 = {DW{1'b0}};
    d2 = {DW{1'b0}};
    case (phase_reg)
      2'h0: d1 = chroma_sel;
      2'h1: d2 = chroma_sel;
      2'h2: d1 = -chroma_sel;
      2'h3: d2 = -chroma_sel;
      default: d1 = {DW{1'b0}};
    endcase
  end
  wire signed [DW+8:0] g1 = d1 * $signed({1'b0, u_gain_reg});
  wire signed [DW+8:0] g2 = d2 * $signed({1'b0, v_gain_reg});

  // Optional one-line-averaging chroma comb in the vertical path
  // Previous sample stands in for the line store, which sits in the scaler
  reg signed [DW-1:0] c1_prev;
  reg signed [DW-1:0] c2_prev;
  wire signed [DW:0]  c1_avg = {g1[DW+6], g1[DW+6:7]} + {c1_prev[DW-1], c1_prev};
  wire signed [DW:0]  c2_avg = {g2[DW+6], g2[DW+6:7]} + {c2_prev[DW-1], c2_prev};
  wire        comb_on = path_reg[`PC_COMB_EN] && path_reg[`PC_SCALE_EN];

  // Output stage
  // Data outputs move only on valid samples; a stalled source holds them
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      luma_out  <= {DW{1'b0}};
      cd1_out   <= {DW{1'b0}};
      cd2_out   <= {DW{1'b0}};
      c1_prev   <= {DW{1'b0}};
      c2_prev   <= {DW{1'b0}};
      iq_mode   <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      out_valid <= sample_valid;
      iq_mode   <= is_ntsc;
      if (sample_valid)
      begin
        luma_out <= luma_sel;
        c1_prev  <= g1[DW+6:7];
        c2_prev  <= g2[DW+6:7];
        cd1_out  <= comb_on ? c1_avg[DW:1] : g1[DW+6:7];
        cd2_out  <= comb_on ? c2_avg[DW:1] : g2[DW+6:7];
      end
    end
  end
endmodule

// File: src/yc_sep_consts.vh
// Constants for the video standard select and Y/C separation block
// Assumes inclusion by the design module and the bench; definitions only
// Notes on behaviour
// - Accepts 525/60 and 625/50 standards, 3.58 or 4.43 MHz subcarrier, and SECAM.
// - Standard code: 001,010,011,100,101,111,110 select the seven standards.
// - Composite input: band-pass filter gives chroma, notch filter gives luma.
// - Demodulator outputs I/Q for NTSC family, U/V for PAL and SECAM.
// - Optional chroma comb after demodulation, within the vertical scaling path.
// - S-Video: luma bypasses separation, chroma goes straight to demodulator.
// - Scaling, cropping and decimation enables are independent of each other.
// - Datapath runs on internal halved reference clock, never exported.
`ifndef YC_SEP_CONSTS_VH
`define YC_SEP_CONSTS_VH
// Register byte addresses
`define ADDR_STD_CTRL    8'h04
`define ADDR_HSTART      8'h08
`define ADDR_VSTART      8'h0c
`define ADDR_VHEIGHT     8'h10
`define ADDR_WIN_HI      8'h14
`define ADDR_HWIDTH      8'h18
`define ADDR_HRATIO      8'h1c
`define ADDR_AGC_GATE    8'h20
`define ADDR_BURST_GATE  8'h24
`define ADDR_PATH_CTRL   8'h28
`define ADDR_GAINS       8'h2c
`define ADDR_STATUS      8'h30
// Standard select field and codes
`define STD_LSB          0
`define STD_MSB          2
`define STD_NTSC_M       3'h1
`define STD_NTSC_J       3'h2
`define STD_PAL_BDGHI    3'h3
`define STD_PAL_M        3'h4
`define STD_PAL_N        3'h5
`define STD_SECAM        3'h6
`define STD_PAL_NC       3'h7
// Path control bit positions
`define PC_SVIDEO        0
`define PC_SEP_EN        1
`define PC_COMB_EN       2
`define PC_SCALE_EN      3
`define PC_WINDOW_HIGH_BITS_EN       4
`define PC_DECIM_EN      5
// Reset values
`define RST_STD          3'h1
`define RST_HRATIO       16'h02ac
`define RST_AGC          8'h70
`define RST_BURST        8'h5d
`define RST_PATH         8'h02
`define RST_GAINS        8'h80
`define RST_BYTE         8'h00
`endif

// File: tb/yc_sep_checker.sv
// Concurrent checks on the standard select block's ports
// Assumes one clock domain and a bind onto yc_sep
`timescale 1ns/100ps
module yc_sep_checker (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Register bus
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  // Video stream
  input wire        sample_valid,
  input wire        out_valid,
  input wire        iq_mode
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bus answers, holds and refusals
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed");
  rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  rd_resp_a: assert property (s_axi_rvalid |-> !s_axi_rresp[0])
    else $error("bad read response");
  // Stream qualifier and standard stability
  out_follow_a: assert property (sample_valid |=> out_valid)
    else $error("output valid missing");
  std_keep_a: assert property ((aresetn && !s_axi_wvalid) [*4] |=> $stable(iq_mode))
    else $error("standard changed without write");
  // Main scenarios
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($fell(iq_mode));
endmodule

bind yc_sep yc_sep_checker i_yc_sep_checker (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_rresp, .sample_valid, .out_valid, .iq_mode);

// File: tb/video_source.sv
// Digitized composite and S-Video sample source
// Assumes samples arrive in the aclk domain
`timescale 1ns/100ps
module video_source (
  // Clock and reset
  input wire       aclk,
  input wire       aresetn,
  // Pace control
  input wire       slow,
  // Samples
  output reg [7:0] comp_in,
  output reg [7:0] chroma_in,
  output reg       sample_valid
);
  reg [7:0] cnt_reg;
  // Ramp patterns, changing every sample
  always @(posedge aclk)
  begin
    cnt_reg <= aresetn ? cnt_reg + 8'h01 : 8'h00;
    comp_in <= cnt_reg * 8'h25;
    chroma_in <= ~cnt_reg;
    sample_valid <= aresetn && (!slow || cnt_reg[0]);
  end
endmodule

// File: tb/video_standard_yc_separation_bench.sv
// Bench for the standard select and Y/C block
// Assumes the design header and a 100 MHz clock
`timescale 1ns/100ps
`include "yc_sep_consts.vh"
module video_standard_yc_separation_bench;
  reg        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, slow, ta, l;
  reg        tw;
  reg [3:0]  s_axi_wstrb;
  reg [7:0]  s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata, d, v;
  reg [1:0]  r;
  integer    failures, comparisons, c;
  wire       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire       sample_valid, iq_mode, out_valid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] comp_in, chroma_in, luma_out, cd1_out, cd2_out;
  // Design and sample source
  yc_sep #(.DW(8)) i_yc_sep (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .comp_in, .chroma_in, .sample_valid, .luma_out, .cd1_out, .cd2_out, .iq_mode, .out_valid);
  video_source i_video_source (.aclk, .aresetn, .slow, .comp_in, .chroma_in, .sample_valid);
  // Compare and count
  task chk(input [31:0] s, input [31:0] e);
  begin
    comparisons = comparisons + 1;
    if (s !== e)
    begin
      failures = failures + 1;
      $display("unexpected %0t: got %h want %h", $time, s, e);
    end
  end
  endtask
  // Bus write, address and data offered together
  task wr(input [7:0] a, input [31:0] w, output [1:0] rs);
  begin
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= w;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    @(negedge aclk);
    while (s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid)
    begin
      ta = s_axi_awready;
      tw = s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      @(negedge aclk);
    end
    rs = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  end
  endtask
  // Bus read
  task rd(input [7:0] a, output [31:0] q, output [1:0] rs);
  begin
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(negedge aclk);
    while (s_axi_arvalid || !s_axi_rvalid)
    begin
      ta = s_axi_arready;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      @(negedge aclk);
    end
    q = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  end
  endtask
  // Read one register and compare
  task rc(input [7:0] a, input [31:0] e);
  begin
    rd(a, d, r);
    chk(d, e);
    chk(r, 0);
  end
  endtask
  // Counts, verdict and end of run
  task test_done;
  begin
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  // Clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Watchdog
  initial
  begin
    #300000;
    failures = failures + 1;
    test_done;
  end
  // Test sequence
  initial
  begin
    {failures, comparisons, aresetn, slow} = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    s_axi_wstrb = 4'hf;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`ADDR_STD_CTRL, 32'h1);
    rc(`ADDR_HRATIO, 32'h2ac);
    rc(`ADDR_AGC_GATE, 32'h70);
    rc(`ADDR_BURST_GATE, 32'h5d);
    rc(`ADDR_PATH_CTRL, 32'h2);
    rc(`ADDR_GAINS, 32'h8080);
    // Every standard code with its square-pixel settings
    for (c = 1; c < 8; c = c + 1)
    begin
      l = (c < 3) || (c == 4);
      wr(`ADDR_STD_CTRL, c, r);
      wr(`ADDR_HRATIO, l ? 32'h2ac : 32'h33c, r);
      wr(`ADDR_AGC_GATE, l ? 32'h70 : 32'h7f, r);
      wr(`ADDR_BURST_GATE, l ? 32'h5d : (c == 6 ? 32'ha0 : 32'h72), r);
      wr(`ADDR_HWIDTH, l ? 32'hc3 : (c == 7 ? 32'hb0 : 32'hec), r);
      rc(`ADDR_STD_CTRL, c);
      rc(`ADDR_BURST_GATE, l ? 32'h5d : (c == 6 ? 32'ha0 : 32'h72));
      rc(`ADDR_HWIDTH, l ? 32'hc3 : (c == 7 ? 32'hb0 : 32'hec));
      rd(`ADDR_STATUS, d, r);
      chk(d & 32'he, {c == 6, l, c < 3, 1'b0});
      chk(iq_mode, c < 3);
    end
    // Reserved code keeps the previous standard
    wr(`ADDR_STD_CTRL, 0, r);
    chk(r, 0);
    rc(`ADDR_STD_CTRL, 7);
    // Unmapped address
    wr(8'h40, 32'h5a, r);
    chk(r, 2);
    rd(8'h40, d, r);
    chk({d, r}, 2);
    // Comb and reduction enables stand alone
    for (c = 2; c < 6; c = c + 1)
    begin
      wr(`ADDR_PATH_CTRL, 2 | (1 << c), r);
      rc(`ADDR_PATH_CTRL, 2 | (1 << c));
    end
    // Monochrome: separation off, both gains zero, one lane at a time
    wr(`ADDR_PATH_CTRL, 0, r);
    s_axi_wstrb <= 4'h1;
    wr(`ADDR_GAINS, 0, r);
    rc(`ADDR_GAINS, 32'h8000);
    s_axi_wstrb <= 4'h2;
    wr(`ADDR_GAINS, 0, r);
    s_axi_wstrb <= 4'hf;
    rc(`ADDR_GAINS, 0);
    repeat (8) @(negedge aclk);
    chk({cd1_out, cd2_out}, 0);
    // S-Video: luma straight through
    wr(`ADDR_PATH_CTRL, 1, r);
    wr(`ADDR_GAINS, 32'h8080, r);
    @(negedge aclk);
    v = comp_in;
    @(negedge aclk);
    chk(luma_out, v);
    // Paced source: output valid trails sample valid by one cycle
    slow <= 1'b1;
    @(negedge aclk);
    for (c = 0; c < 4; c = c + 1)
    begin
      v = sample_valid;
      @(negedge aclk);
      chk(out_valid, v);
    end
    test_done;
  end
endmodule
